/* verilog/rtc_event_map.vh */
// register offsets, field positions and reset values of the rtc event block
`ifndef RTC_EVENT_MAP_VH
`define RTC_EVENT_MAP_VH
`define EVENT_FLAG_REG_OFFSET   12'h00C
`define IRQ_WAKE_EN_REG_OFFSET  12'h010
`define DIVIDER_CTRL_OFFSET     12'h014
`define EVENT_FLAG_RESET        32'h0000_0000
`define IRQ_WAKE_EN_RESET       32'h0000_0000
`define DIVIDER_CTRL_RESET      4'h0
`define WRAP_FLAG_BIT           2
`define MATCH_FLAG_BIT          1
`define TICK_FLAG_BIT           0
`define WRAP_IRQ_BIT            2
`define MATCH_IRQ_BIT           1
`define TICK_IRQ_BIT            0
`define WRAP_WAKE_BIT           10
`define MATCH_WAKE_BIT          9
`define TICK_WAKE_BIT           8
`define DIVIDER_SEL_MSB         11
`define DIVIDER_SEL_LSB         8
`define COUNTER_ALL_ONES        32'hFFFF_FFFF
`define COUNTER_ZERO            32'h0000_0000
`endif

/* verilog/tick_divider.v */
// seconds tick divider: source clock divided by two to the select power
`timescale 1ns/1ps
`default_nettype none
module tick_divider (
	input  wire        clock,
	input  wire        srst,
	input  wire        sourceTick,
	input  wire        unitEnable,
	input  wire [3:0]  dividerSel,
	output reg         secondsTick_r
);
	reg  [14:0] divCount_r;
	wire [14:0] divMask;
	reg         srcPrev_r;
	wire        srcRise;

	// mask of the counter bits in use; select 0 passes source straight
	assign divMask = (15'h7FFF >> (4'hF - dividerSel));
	assign srcRise = sourceTick & ~srcPrev_r;

	always @(posedge clock) begin
		if (srst) begin
			divCount_r    <= 15'h0000;
			srcPrev_r     <= 1'b0;
			secondsTick_r <= 1'b0;
		end else begin
			srcPrev_r <= sourceTick;
			if (!unitEnable) begin
				divCount_r    <= 15'h0000;
				secondsTick_r <= 1'b0;
			end else if (dividerSel == 4'h0) begin
				secondsTick_r <= sourceTick;
			end else if (srcRise) begin
				// half period reached: toggle the divided clock
				if ((divCount_r & (divMask >> 1)) == (divMask >> 1)) begin
					divCount_r    <= 15'h0000;
					secondsTick_r <= ~secondsTick_r;
				end else begin
					divCount_r <= divCount_r + 15'h0001;
				end
			end
		end
	end
endmodule
`default_nettype wire

/* verilog/rtc_event_flags_irq_wakeup.v */
// rtc event flags, interrupt and wakeup enables with register port
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_event_map.vh"
// How it works
// - wrap flag set on all-ones to zero
// - reading flag register clears all flags except those set in the read cycle
// - match flag on tick fall, count equals compare
// - tick flag on every tick falling edge
// - flags cleared by reset or enable fall
// - enable register cleared only by reset
// - bit 10 lets wrap wake system
// - bit 9 lets match wake system
// - bit 8 lets tick wake system
// - bit 2 lets wrap interrupt
// - bit 1 lets match interrupt
// - bit 0 lets tick interrupt
// - tick clock is source over two-power
module rtc_event_flags_irq_wakeup (
	input  wire        clock,
	input  wire        srst,
	input  wire [11:0] regAddr,
	input  wire [31:0] regWdata,
	input  wire        regWrite,
	input  wire        regRead,
	output reg  [31:0] regRdata,
	input  wire [31:0] timeCounter,
	input  wire [31:0] timeCompareValue,
	input  wire        sourceTick,
	input  wire        clockUnitEnable,
	output reg         secondsTickClock,
	output reg         irqRequest,
	output reg         wakeRequest
);
	reg  [2:0]  eventFlag_r;
	reg  [2:0]  eventFlag_nxt;
	reg  [2:0]  irqEnable_r;
	reg  [2:0]  wakeEnable_r;
	reg  [3:0]  tickDividerSelect_r;
	reg  [31:0] counterPrev_r;
	reg         tickPrev_r;
	reg         unitEnablePrev_r;
	wire        secondsTick;
	wire        tickFall;
	wire        wrapEvent;
	wire        matchEvent;
	wire [2:0]  eventPulse;
	wire        flagRead;

	tick_divider divider (
		.clock         (clock),
		.srst          (srst),
		.sourceTick    (sourceTick),
		.unitEnable    (clockUnitEnable),
		.dividerSel    (tickDividerSelect_r),
		.secondsTick_r (secondsTick)
	);

	assign tickFall   = tickPrev_r & ~secondsTick;
	assign wrapEvent  = (counterPrev_r == `COUNTER_ALL_ONES) && (timeCounter == `COUNTER_ZERO);
	assign matchEvent = tickFall && (timeCounter == timeCompareValue);
	assign eventPulse = {wrapEvent, matchEvent, tickFall};
	assign flagRead   = regRead && (regAddr == `EVENT_FLAG_REG_OFFSET);

	// a new event in the read cycle survives: set wins over read clear
	always @* begin
		eventFlag_nxt = eventFlag_r;
		if (flagRead) begin
			eventFlag_nxt = 3'b000;
		end
		eventFlag_nxt = eventFlag_nxt | eventPulse;
		if (unitEnablePrev_r && !clockUnitEnable) begin
			eventFlag_nxt = 3'b000;
		end
	end

	always @(posedge clock) begin
		if (srst) begin
			eventFlag_r      <= 3'b000;
			counterPrev_r    <= `COUNTER_ZERO;
			tickPrev_r       <= 1'b0;
			unitEnablePrev_r <= 1'b0;
		end else begin
			eventFlag_r      <= eventFlag_nxt;
			counterPrev_r    <= timeCounter;
			tickPrev_r       <= secondsTick;
			unitEnablePrev_r <= clockUnitEnable;
		end
	end

	// enables survive unit disable; only the reset clears them
	always @(posedge clock) begin
		if (srst) begin
			irqEnable_r         <= 3'b000;
			wakeEnable_r        <= 3'b000;
			tickDividerSelect_r <= `DIVIDER_CTRL_RESET;
		end else if (regWrite) begin
			if (regAddr == `IRQ_WAKE_EN_REG_OFFSET) begin
				irqEnable_r  <= regWdata[`WRAP_IRQ_BIT:`TICK_IRQ_BIT];
				wakeEnable_r <= regWdata[`WRAP_WAKE_BIT:`TICK_WAKE_BIT];
			end
			if (regAddr == `DIVIDER_CTRL_OFFSET) begin
				tickDividerSelect_r <= regWdata[`DIVIDER_SEL_MSB:`DIVIDER_SEL_LSB];
			end
		end
	end

	always @(posedge clock) begin
		if (srst) begin
			regRdata         <= 32'h0000_0000;
			irqRequest       <= 1'b0;
			wakeRequest      <= 1'b0;
			secondsTickClock <= 1'b0;
		end else begin
			regRdata <= 32'h0000_0000;
			if (regRead) begin
				case (regAddr)
					`EVENT_FLAG_REG_OFFSET: begin
						regRdata <= {29'h0000_0000, eventFlag_r};
					end
					`IRQ_WAKE_EN_REG_OFFSET: begin
						regRdata <= {21'h00_0000, wakeEnable_r, 5'h00, irqEnable_r};
					end
					`DIVIDER_CTRL_OFFSET: begin
						regRdata <= {20'h0_0000, tickDividerSelect_r, 8'h00};
					end
					default: begin
						regRdata <= 32'h0000_0000;
					end
				endcase
			end
			// level irq follows flags, so a read drops it
			irqRequest  <= |(eventFlag_nxt & irqEnable_r);
			// wake is a one-cycle pulse in the cycle after each cycle with an enabled event
			wakeRequest      <= |(eventPulse & wakeEnable_r);
			secondsTickClock <= secondsTick;
		end
	end
endmodule
`default_nettype wire

/* tb/rtc_event_props.sv */
// port checker for the rtc event block
`timescale 1ns/1ps
`default_nettype none
module rtc_event_props (
	input wire        clock,
	input wire        srst,
	input wire [11:0] regAddr,
	input wire        regRead,
	input wire [31:0] regRdata,
	input wire        clockUnitEnable,
	input wire        secondsTickClock,
	input wire        irqRequest,
	input wire        wakeRequest
);
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	wire rdF = regRead && regAddr == 12'h00C;
	rdata_idle_a: assert property (!regRead |=> regRdata == 0) else $error("read data not idle");
	flag_rsvd_a: assert property (rdF |=> regRdata[31:3] == 0) else $error("flag reserved set");
	en_rsvd_a: assert property (regRead && regAddr == 12'h010 |=> regRdata[31:11] == 0 && regRdata[7:3] == 0)
		else $error("enable reserved set");
	irq_flag_a: assert property (irqRequest && rdF |=> regRdata[2:0] != 0) else $error("irq without flag");
	tick_flag_a: assert property ($fell(secondsTickClock) && rdF |=> regRdata[0]) else $error("tick lost");
	off_clear_a: assert property ($fell(clockUnitEnable) |=> !irqRequest) else $error("irq after disable");
	rst_quiet_a: assert property ($fell(srst) |-> !irqRequest && !wakeRequest) else $error("busy after reset");
	div_rsvd_a: assert property (regRead && regAddr == 12'h014 |=> regRdata[7:0] == 0) else $error("div bits");
endmodule
bind rtc_event_flags_irq_wakeup rtc_event_props i_rtc_event_props (.clock(clock), .srst(srst), .regAddr(regAddr),
	.regRead(regRead), .regRdata(regRdata), .clockUnitEnable(clockUnitEnable),
	.secondsTickClock(secondsTickClock), .irqRequest(irqRequest), .wakeRequest(wakeRequest));
`default_nettype wire

/* tb/tb_rtc_event_flags_irq_wakeup.sv */
// bench for the rtc event block
`timescale 1ns/1ps
`default_nettype none
module tb_rtc_event_flags_irq_wakeup;
	logic        clock = 1'b0, srst = 1'b1, regWrite = 1'b0, regRead = 1'b0, sourceTick = 1'b0, clockUnitEnable = 1'b0;
	logic [11:0] regAddr = 12'h000;
	logic [31:0] regWdata = '0, timeCounter = '0, timeCompareValue = 32'h0000_0007, d;
	wire  [31:0] regRdata;
	wire         secondsTickClock, irqRequest, wakeRequest;
	int          num_errors = 0, n_tests = 0, cyc = 0, wakes = 0, w0;
	rtc_event_flags_irq_wakeup i_rtc_event_flags_irq_wakeup (.clock(clock), .srst(srst), .regAddr(regAddr),
		.regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .timeCounter(timeCounter),
		.timeCompareValue(timeCompareValue), .sourceTick(sourceTick), .clockUnitEnable(clockUnitEnable),
		.secondsTickClock(secondsTickClock), .irqRequest(irqRequest), .wakeRequest(wakeRequest));
	task chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			num_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task wr(input logic [11:0] a, input logic [31:0] v);
		@(posedge clock);
		regAddr <= a;
		regWdata <= v;
		regWrite <= 1'b1;
		@(posedge clock);
		regWrite <= 1'b0;
	endtask
	task rd(input logic [11:0] a);
		@(posedge clock);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clock);
		regRead <= 1'b0;
		@(posedge clock);
		d = regRdata;
	endtask
	// divide by one, so one source pulse is one tick fall
	task tick;
		@(posedge clock);
		sourceTick <= 1'b1;
		repeat (3) @(posedge clock);
		sourceTick <= 1'b0;
		repeat (4) @(posedge clock);
	endtask
	task end_sim;
		$display("compares %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial forever #12.5 clock = ~clock;
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (wakeRequest === 1'b1) wakes <= wakes + 1;
		if (cyc == 3000) begin
			num_errors++;
			end_sim;
		end
	end
	initial begin
		repeat (10) @(posedge clock);
		srst <= 1'b0;
		rd(12'h00C); chk(d, 0);
		rd(12'h010); chk(d, 0);
		rd(12'h020); chk(d, 0);
		wr(12'h010, 32'hFFFF_FFFF);
		rd(12'h010); chk(d, 32'h0000_0707);
		wr(12'h00C, 32'h0000_0007);
		rd(12'h00C); chk(d, 0);
		$display("test registers done");
		@(posedge clock);
		clockUnitEnable <= 1'b1;
		w0 = wakes;
		tick;
		chk(irqRequest, 1);
		chk(wakes - w0, 1);
		rd(12'h00C); chk(d, 1);
		rd(12'h00C); chk(d, 0);
		chk(irqRequest, 0);
		@(posedge clock);
		timeCompareValue <= 32'h0000_0000;
		tick;
		rd(12'h00C); chk(d, 3);
		$display("test tick and match done");
		wr(12'h010, 32'h0000_0202);
		w0 = wakes;
		tick;
		chk(wakes - w0, 1);
		chk(irqRequest, 1);
		rd(12'h00C); chk(d, 3);
		wr(12'h010, 32'h0000_0400);
		timeCompareValue <= 32'h0000_0007;
		timeCounter <= 32'hFFFF_FFFF;
		repeat (3) @(posedge clock);
		w0 = wakes;
		timeCounter <= 32'h0000_0000;
		repeat (4) @(posedge clock);
		chk(wakes - w0, 1);
		chk(irqRequest, 0);
		rd(12'h00C); chk(d, 4);
		$display("test wrap done");
		wr(12'h010, 32'h0000_0001);
		tick;
		chk(irqRequest, 1);
		clockUnitEnable <= 1'b0;
		repeat (3) @(posedge clock);
		chk(irqRequest, 0);
		rd(12'h00C); chk(d, 0);
		rd(12'h010); chk(d, 1);
		$display("test disable done");
		end_sim;
	end
endmodule
`default_nettype wire
